/* logic/tcps_clock_select.sv */
// Timer clock prescaler and count-enable selection for four timers.
`timescale 1ns/1ps
`include "tcps_map.svh"
// Overview of operation
// R1 - Prescale codes 00, 01 and 10 give a tick every 12, 4 and 48 system clocks.
// R2 - Prescale code 11 gives the external clock divided by 8, synchronized to the system clock.
// R3 - Timer one counts prescaled ticks when bit 3 is clear and every system clock when set.
// R4 - Timer one ignores bit 3 in counter mode and counts its external input instead.
// R5 - Timer zero counts prescaled ticks when bit 2 is clear and every system clock when set.
// R6 - Timer zero ignores bit 2 in counter mode and counts its external input instead.
// R7 - Bit 4 picks the alternate source or the system clock for timer two or its low byte.
// R8 - Bit 5 picks the alternate source or the system clock for timer two's high byte.
// R9 - Bit 6 picks the alternate source or the system clock for timer three or its low byte.
// R10 - Bit 7 picks the alternate source or the system clock for timer three's high byte.
// R11 - The control register lives at address 0x8E on every page and resets to zero.
// R12 - In counter mode timers zero and one count falling edges on their input pins.
// R13 - The alternate clock is the system clock divided by 12 or the external clock divided by 8.
// R14 - Every clock is a one-cycle count enable, the external clock edge-detected after two flops.
module tcps_clock_select
  import tcps_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic extClk,
  input wire logic timer0Pin,
  input wire logic timer1Pin,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic sfrRead,
  input wire logic [7:0] sfrWdata,
  input wire logic timer0_counter_mode_sel,
  input wire logic timer1_counter_mode_sel,
  input wire logic timer2_alt_clock_sel,
  input wire logic timer3_alt_clock_sel,
  output logic [7:0] sfrRdata,
  output logic [7:0] timer_clock_select_register,
  output tcps_ticks_s countTick
);

  // ---------------------------------------------------------------
  // Register access
  // ---------------------------------------------------------------
  // The page select is deliberately not decoded: the register is seen from every page.
  wire logic hitClkSel = (sfrAddr == `TCPS_CLKSEL_ADDR); // R11
  logic [7:0] next_rdata;
  assign next_rdata = (sfrRead && hitClkSel) ? timer_clock_select_register : 8'h00;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer_clock_select_register <= `TCPS_CLKSEL_RESET; // R11
      sfrRdata <= 8'h00;
    end else begin
      if (sfrWrite && hitClkSel) begin
        timer_clock_select_register <= sfrWdata; // R11
      end
      sfrRdata <= next_rdata;
    end
  end

  wire tcps_scale_e scale = tcps_scale_e'(timer_clock_select_register[1:0]);

  // ---------------------------------------------------------------
  // Synchronizers for pin and external clock inputs
  // ---------------------------------------------------------------
  logic [2:0] syncA;
  logic [2:0] syncB;
  logic [2:0] syncPrev;
  wire logic [2:0] rawIn = {extClk, timer1Pin, timer0Pin};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      syncA <= 3'h0;
      syncB <= 3'h0;
      syncPrev <= 3'h0;
    end else begin
      syncA <= rawIn; // R14
      syncB <= syncA;
      syncPrev <= syncB;
    end
  end

  // Falling edges on the timer pins, rising edges of the external clock.
  wire logic t0Fall = syncPrev[0] & ~syncB[0]; // R12
  wire logic t1Fall = syncPrev[1] & ~syncB[1]; // R12
  wire logic extRise = ~syncPrev[2] & syncB[2]; // R14

  // ---------------------------------------------------------------
  // Dividers
  // ---------------------------------------------------------------
  logic [5:0] preCnt;
  logic [3:0] altCnt;
  logic [2:0] extCnt;
  logic [5:0] preLimit;
  assign preLimit = (scale == TCPS_DIV4) ? `TCPS_DIV_4 :
                    (scale == TCPS_DIV48) ? `TCPS_DIV_48 : `TCPS_DIV_12; // R1

  wire logic preWrap = (preCnt >= preLimit);
  wire logic altWrap = (altCnt == 4'(`TCPS_DIV_12)); // R13
  wire logic extWrap = extRise && (extCnt == `TCPS_EXT_DIV); // R2

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      preCnt <= 6'h00;
      altCnt <= 4'h0;
      extCnt <= 3'h0;
    end else begin
      preCnt <= preWrap ? 6'h00 : preCnt + 6'h01; // R1
      altCnt <= altWrap ? 4'h0 : altCnt + 4'h1; // R13
      if (extRise) begin
        extCnt <= extCnt + 3'h1; // R2
      end
    end
  end

  // ---------------------------------------------------------------
  // Selection of count enables
  // ---------------------------------------------------------------
  wire logic preTick = (scale == TCPS_EXT8) ? extWrap : preWrap; // R1 R2
  wire logic alt2Tick = timer2_alt_clock_sel ? extWrap : altWrap; // R13
  wire logic alt3Tick = timer3_alt_clock_sel ? extWrap : altWrap; // R13
  wire logic [7:0] r = timer_clock_select_register;

  // A set select bit gives a tick on every system clock, a clear one the divided source.
  function automatic logic pick_tick(input logic sysSel, input logic divided);
    pick_tick = sysSel ? 1'b1 : divided;
  endfunction

  tcps_ticks_s next_tick;
  assign next_tick.timer0 = timer0_counter_mode_sel ? t0Fall :
                            pick_tick(r[`TCPS_BIT_T0], preTick); // R5 R6
  assign next_tick.timer1 = timer1_counter_mode_sel ? t1Fall :
                            pick_tick(r[`TCPS_BIT_T1], preTick); // R3 R4
  assign next_tick.timer2Low = pick_tick(r[`TCPS_BIT_T2L], alt2Tick); // R7
  assign next_tick.timer2High = pick_tick(r[`TCPS_BIT_T2H], alt2Tick); // R8
  assign next_tick.timer3Low = pick_tick(r[`TCPS_BIT_T3L], alt3Tick); // R9
  assign next_tick.timer3High = pick_tick(r[`TCPS_BIT_T3H], alt3Tick); // R10

  // Registered enables cost one cycle of latency but keep the timer inputs glitch free.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      countTick <= '0;
    end else begin
      countTick <= next_tick; // R14
    end
  end

endmodule // tcps_clock_select

/* logic/tcps_map.svh */
// Address, field positions, reset value and divide ratios of the timer clock select block.
`ifndef TCPS_MAP_SVH
`define TCPS_MAP_SVH
`define TCPS_CLKSEL_ADDR 8'h8E
`define TCPS_CLKSEL_RESET 8'h00
`define TCPS_BIT_T0 2
`define TCPS_BIT_T1 3
`define TCPS_BIT_T2L 4
`define TCPS_BIT_T2H 5
`define TCPS_BIT_T3L 6
`define TCPS_BIT_T3H 7
`define TCPS_DIV_12 6'd11
`define TCPS_DIV_4 6'd3
`define TCPS_DIV_48 6'd47
`define TCPS_EXT_DIV 3'd7
`endif

/* logic/tcps_pkg.sv */
// Types shared by the timer clock select block.
package tcps_pkg;
  typedef enum logic [1:0] {
    TCPS_DIV12 = 2'h0,
    TCPS_DIV4 = 2'h1,
    TCPS_DIV48 = 2'h2,
    TCPS_EXT8 = 2'h3
  } tcps_scale_e;
  typedef struct packed {
    logic timer3High;
    logic timer3Low;
    logic timer2High;
    logic timer2Low;
    logic timer1;
    logic timer0;
  } tcps_ticks_s;
endpackage

/* verif/tcps_clock_select_chk.sv */
// Checker for the clock select block.
`timescale 1ns/1ps
module tcps_clock_select_chk import tcps_pkg::*; (
  input wire logic clk_sys, rst_n, sfrWrite, sfrRead, timer0_counter_mode_sel,
  input wire logic timer1_counter_mode_sel,
  input wire logic [7:0] sfrAddr, sfrWdata, sfrRdata, timer_clock_select_register,
  input wire tcps_ticks_s countTick
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire [7:0] r = timer_clock_select_register;
  wire [5:0] t = countTick;
  wire hit = sfrAddr == 8'h8E;
  property p_t0; r[2] && !timer0_counter_mode_sel |=> t[0]; endproperty
  a_t0: assert property (p_t0) else $error("t0");
  property p_t1; r[3] && !timer1_counter_mode_sel |=> t[1]; endproperty
  a_t1: assert property (p_t1) else $error("t1");
  property p_t2l; r[4] |=> t[2]; endproperty
  a_t2l: assert property (p_t2l) else $error("t2l");
  property p_t2h; r[5] |-> ##1 t[3]; endproperty
  a_t2h: assert property (p_t2h) else $error("t2h");
  property p_t3l; r[6] |=> t[4]; endproperty
  a_t3l: assert property (p_t3l) else $error("t3l");
  property p_t3h; r[7] ##1 r[7] |-> t[5]; endproperty
  a_t3h: assert property (p_t3h) else $error("t3h");
  property p_wr; sfrWrite && hit |=> r == $past(sfrWdata); endproperty
  a_wr: assert property (p_wr) else $error("wr");
  property p_rd; sfrRead && hit |=> sfrRdata == $past(r); endproperty
  a_rd: assert property (p_rd) else $error("rd");
  property p_miss; sfrRead && !hit |=> sfrRdata == 8'h00; endproperty
  a_miss: assert property (p_miss) else $error("miss");
endmodule // tcps_clock_select_chk
bind tcps_clock_select tcps_clock_select_chk i_chk (.*);

/* verif/tcps_clock_select_tb.sv */
// Bench for the clock select block.
`timescale 1ns/1ps
module tcps_clock_select_tb import tcps_pkg::*; ;
  logic clk_sys = 0, rst_n = 0, extClk = 0, pin = 1, wr = 0, rd = 0, m = 0;
  logic [7:0] a = 8'h00, d = 8'h00, q, r;
  logic [15:0] n [6], b [6], pl [6] = '{16'h0008, 16'h0118, 16'h0202, 16'h0304, 16'h0C60, 16'hFC06};
  tcps_ticks_s tick;
  int mismatches = 0, compares = 0;
  always #10 clk_sys = ~clk_sys;
  always #160 pin = ~pin;
  initial #5 forever #30 extClk = ~extClk;
  tcps_clock_select i_tcps_clock_select (.clk_sys, .rst_n, .extClk, .timer0Pin(pin),
    .timer1Pin(pin), .sfrAddr(a), .sfrWrite(wr), .sfrRead(rd), .sfrWdata(d), .sfrRdata(q),
    .timer0_counter_mode_sel(m), .timer1_counter_mode_sel(m), .timer2_alt_clock_sel(1'b0),
    .timer3_alt_clock_sel(1'b1), .timer_clock_select_register(r), .countTick(tick));
  tcps_timer_model i_tcps_timer_model (.clk_sys, .countTick(tick), .tally(n));
  task automatic chk(input logic [15:0] got, exp);
    compares++;
    mismatches += int'(got !== exp);
    if (got !== exp) $display("unexpected %0t got %h", $time, got);
  endtask
  task automatic acc(input logic w, input logic [7:0] x, y);
    @(posedge clk_sys) #2 {wr, rd, a, d} = {w, !w, x, y};
    @(posedge clk_sys) #2 {wr, rd} = 2'b00;
  endtask
  task automatic win(input logic [15:0] p);
    m = p[15];
    acc(1, 8'h8E, p[15:8]);
    #959 b = n;
    #1920 for (int i = 0; i < 6; i++)
      chk(n[i] - b[i], i < 2 ? p[7:0] : m ? 8'h60 : i < 4 ? 8'h08 : 8'h04);
  endtask
  task automatic final_report(input int late);
    mismatches += late;
    if (mismatches == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial #40000 final_report(1);
  initial begin
    #72 rst_n = 1;
    chk(r, 8'h00);
    foreach (pl[k]) win(pl[k]);
    acc(0, 8'h8E, 8'h00);
    chk(q, 8'hFC);
    acc(0, 8'h8F, 8'h00);
    chk(q, 8'h00);
    final_report(0);
  end
endmodule // tcps_clock_select_tb

/* verif/tcps_timer_model.sv */
// Timer cores tallying the count enables.
`timescale 1ns/1ps
module tcps_timer_model import tcps_pkg::*; (
  input wire logic clk_sys, input wire tcps_ticks_s countTick, output logic [15:0] tally [6]
);
  initial tally = '{default: 16'h0000};
  // Enables are unknown before the first reset edge, so only a known high counts.
  always @(posedge clk_sys) for (int i = 0; i < 6; i++)
    tally[i] <= tally[i] + ((countTick[i] === 1'b1) ? 16'h0001 : 16'h0000);
endmodule // tcps_timer_model
